// >>> rtl/sss_defs.vh
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH
// number of shift stages
`define SSS_STAGES 8
// depth of the fifo in the serial data path
`define SSS_FIFO_DEPTH 16
// reset value of the shift, storage and parallel output registers
`define SSS_RST_BYTE 8'h00
// early serial output taps the last stage
`define SSS_LAST_STAGE 7
`endif

// >>> rtl/sss_fifo.v
`timescale 1ns/1ps
`default_nettype none
module sss_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             srst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output reg              out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	reg  [AW:0]      count_reg;
	wire             push;
	wire             pop;
	wire             store_empty;

	// the output register counts as one extra slot
	assign store_empty = (count_reg == {(AW+1){1'b0}});
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign push = in_valid & in_ready;
	assign pop = (~out_valid | out_ready) & ~store_empty;

	// storage array write
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers, count and registered read port
	always @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			out_valid  <= 1'b0;
			out_data   <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_data   <= mem[rd_ptr_reg];
				out_valid  <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // sss_fifo
`default_nettype wire

// >>> rtl/sss_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sss_defs.vh"
module sss_top #(
	parameter STAGES = `SSS_STAGES,
	parameter DEPTH  = `SSS_FIFO_DEPTH
) (
	input  wire              ref_clk,
	input  wire              srst,
	input  wire              serial_in,
	input  wire              serial_in_valid,
	output wire              serial_in_ready,
	input  wire              shift_clock,
	input  wire              latch_gate,
	input  wire              output_enable,
	output reg  [STAGES-1:0] parallel_out,
	output reg  [STAGES-1:0] parallel_out_oe_n,
	output reg               early_serial_out,
	output reg               late_serial_out,
	output reg               bit_dropped
);
	reg  [STAGES-1:0] shift_reg;
	reg  [STAGES-1:0] shift_next;
	reg  [STAGES-1:0] store_reg;
	reg  [STAGES-1:0] store_next;
	reg               clk_d_reg;
	wire              rise;
	wire              fall;
	wire              fifo_bit;
	wire              fifo_valid;
	wire              fifo_ready;

	// edge detection of the sampled shift clock
	assign rise = shift_clock & ~clk_d_reg;
	assign fall = ~shift_clock & clk_d_reg;
	// a bit leaves the fifo on each rising shift edge while the fifo holds one
	assign fifo_ready = rise;

	// serial data waits here until a rising edge consumes it
	sss_fifo #(
		.WIDTH (1),
		.DEPTH (DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (ref_clk),
		.srst      (srst),
		.in_data   (serial_in),
		.in_valid  (serial_in_valid),
		.in_ready  (serial_in_ready),
		.out_data  (fifo_bit),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready)
	);

	// next shift and storage contents
	always @* begin
		shift_next = shift_reg;
		if (rise) begin
			shift_next = {shift_reg[STAGES-2:0], fifo_bit};
		end
		store_next = store_reg;
		if (latch_gate) begin
			store_next = shift_next;
		end
	end

	// shift chain, storage latch and serial outputs
	always @(posedge ref_clk) begin
		if (srst) begin
			clk_d_reg        <= 1'b0;
			shift_reg        <= `SSS_RST_BYTE;
			store_reg        <= `SSS_RST_BYTE;
			early_serial_out <= 1'b0;
			late_serial_out  <= 1'b0;
			bit_dropped      <= 1'b0;
		end else begin
			clk_d_reg <= shift_clock;
			shift_reg <= shift_next;
			store_reg <= store_next;
			bit_dropped <= rise & ~fifo_valid; // empty fifo shifts its held out_data again
			if (rise) begin
				early_serial_out <= shift_next[`SSS_LAST_STAGE];
			end
			if (fall) begin
				late_serial_out <= shift_reg[`SSS_LAST_STAGE];
			end
		end
	end

	// parallel drivers; enable is active low at the port
	always @(posedge ref_clk) begin
		if (srst) begin
			parallel_out      <= `SSS_RST_BYTE;
			parallel_out_oe_n <= {STAGES{1'b1}};
		end else begin
			parallel_out      <= store_next;
			parallel_out_oe_n <= {STAGES{~output_enable}};
		end
	end
endmodule // sss_top
`default_nettype wire

// >>> test/sss_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: pushes each bit, then gives it one shift clock pulse
module sss_host (
	input  wire logic ref_clk,
	output var  logic serial_in,
	output var  logic serial_in_valid,
	output var  logic shift_clock
);
	initial {serial_in, serial_in_valid, shift_clock} = 3'h0;
	// oldest bit first, a whole byte with latch and enable held as the caller set them
	task send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			{serial_in, serial_in_valid} = {b[i], 1'h1};
			@(posedge ref_clk) #1 {serial_in, serial_in_valid} = {~b[i], 1'h0};
			@(posedge ref_clk) #1 shift_clock = 1'h1;
			repeat (2) @(posedge ref_clk) #1;
			shift_clock = 1'h0;
			@(posedge ref_clk) #1;
		end
	endtask
endmodule // sss_host
`default_nettype wire

// >>> test/sss_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sss_top_chk #(parameter STAGES = 8) (
	input wire logic              ref_clk,
	input wire logic              srst,
	input wire logic              shift_clock,
	input wire logic              latch_gate,
	input wire logic              output_enable,
	input wire logic [STAGES-1:0] parallel_out,
	input wire logic [STAGES-1:0] parallel_out_oe_n,
	input wire logic              early_serial_out,
	input wire logic              late_serial_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// drivers, storage and serial taps against their causes
	chk_oe_on: assert property (output_enable |=> !parallel_out_oe_n)
		else $error("oe on");
	chk_oe_off: assert property (!output_enable |=> &parallel_out_oe_n)
		else $error("oe off");
	chk_store_hold: assert property (!latch_gate |=> $stable(parallel_out))
		else $error("hold");
	chk_store_shift: assert property ($rose(shift_clock) && latch_gate
		&& $stable(latch_gate) |=> parallel_out[STAGES-1:1]
		== $past(parallel_out[STAGES-2:0])) else $error("shift");
	chk_early_tap: assert property ($rose(shift_clock) && latch_gate
		|=> early_serial_out == parallel_out[STAGES-1]) else $error("early");
	chk_early_hold: assert property (!$rose(shift_clock)
		|=> $stable(early_serial_out)) else $error("early hold");
	chk_late_take: assert property ($fell(shift_clock)
		|=> late_serial_out == early_serial_out) else $error("late");
	chk_late_hold: assert property (!$fell(shift_clock)
		|=> $stable(late_serial_out)) else $error("late hold");
	cover property ($rose(shift_clock) && latch_gate);
	cover property ($fell(shift_clock) && !output_enable);
	cover property ($fell(latch_gate));
endmodule // sss_top_chk
bind sss_top sss_top_chk #(.STAGES(STAGES)) i_sss_top_chk (.*);
`default_nettype wire

// >>> test/test_serial_shift_store_register.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_shift_store_register;
	logic        ref_clk = 1'h0, srst = 1'h1, lg = 1'h0, oe = 1'h0;
	logic        si, sv, sc, es, ls;
	logic [7:0]  po, pz, d, st = 8'h00;
	logic [17:0] q[$];
	int          n_fail = 0, checks_done = 0, seed = 30575;
	event        shown;
	sss_top i_sss_top (.ref_clk, .srst, .serial_in(si), .serial_in_valid(sv),
		.serial_in_ready(), .shift_clock(sc), .latch_gate(lg),
		.output_enable(oe), .parallel_out(po), .parallel_out_oe_n(pz),
		.early_serial_out(es), .late_serial_out(ls), .bit_dropped());
	sss_host i_sss_host (.ref_clk, .serial_in(si), .serial_in_valid(sv),
		.shift_clock(sc));
	// clock at 125 MHz
	initial forever #4 ref_clk = ~ref_clk;
	task chk(input logic [17:0] s, input logic [17:0] e);
		checks_done++;
		if (s !== e) n_fail++;
		if (s !== e) $display("[FAIL] outputs exp %h seen %h", e, s);
		$display("test %0d done", checks_done);
	endtask
	// watcher: oldest note against the settled outputs
	always @(shown) chk({po, pz, es, ls}, q.pop_front());
	task close_out;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// every latch and enable mode, idle mode first so all stages are known
	initial begin
		repeat (3) @(posedge ref_clk) #1;
		srst = 1'h0;
		for (int k = 0; k < 5; k++) begin
			{lg, oe} = 2'(k);
			d = 8'($random(seed));
			i_sss_host.send(d);
			if (lg) st = d;
			q.push_back({st, {8{~oe}}, d[7], d[7]});
			-> shown;
		end
		#1 close_out;
	end
	// watchdog, about twelve times the expected run
	initial begin
		#20000 n_fail++;
		close_out;
	end
endmodule // test_serial_shift_store_register
`default_nettype wire
